// ---- inc/iac_pkg.sv ----
// Shared constants, types and helpers of the I/O alarm command handler
// How it works
// - Watchdog expiry clears the device's own watchdog enable
// - Read-preset replies address, power-on then safe hex
// - Set-preset stores both values, replies valid
// - Presets never touch alarm-assigned outputs
// - Commands carry hex address; replies delimiter plus address
// - Bad syntax, comm error, foreign address: silence
// - Enable-alarm with a setting other than M or L gets invalid reply
// - Clear-alarm resets latched alarm, replies valid
// - Clear-counter zeroes input counter, replies valid
// - Disable-alarm stops alarm checking, replies valid
// - Status digit: 0 off, 1 momentary, 2 latched
// - Output byte bit n is output n
// - Input byte bit n is input n
// - Write-output drives outputs from bits, replies valid
// - Alarm-assigned outputs ignore written bits
// - During watchdog expiry write-output is rejected, unchanged
// - Enable-alarm: M momentary, L latched, replies valid
// - Watchdog timeout is eight bits of tenths
package iac_pkg;
  localparam int DIO_W   = 8;
  localparam int BUF_LEN = 12;
  // Characters of the command language
  localparam logic [7:0] CH_TILDE = 8'h7e;
  localparam logic [7:0] CH_AT    = 8'h40;
  localparam logic [7:0] CH_STAR  = 8'h2a;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_BANG  = 8'h21;
  localparam logic [7:0] CH_QUES  = 8'h3f;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_1     = 8'h31;
  localparam logic [7:0] CH_3     = 8'h33;
  localparam logic [7:0] CH_4     = 8'h34;
  localparam logic [7:0] CH_5     = 8'h35;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_C     = 8'h43;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_I     = 8'h49;
  localparam logic [7:0] CH_L     = 8'h4c;
  localparam logic [7:0] CH_M     = 8'h4d;
  localparam logic [7:0] CH_O     = 8'h4f;
  // Command body lengths without checksum
  localparam logic [3:0] LEN_ALIVE = 4'h3;
  localparam logic [3:0] LEN_RDPRE = 4'h4;
  localparam logic [3:0] LEN_AT2   = 4'h5;
  localparam logic [3:0] LEN_ENA   = 4'h6;
  localparam logic [3:0] LEN_WDT   = 4'h7;
  localparam logic [3:0] LEN_DO    = 4'h7;
  localparam logic [3:0] LEN_SETPR = 4'h8;
  // Alarm setting codes
  localparam logic [1:0] ALM_OFF = 2'h0;
  localparam logic [1:0] ALM_MOM = 2'h1;
  localparam logic [1:0] ALM_LAT = 2'h2;
  // Reset values
  localparam logic [7:0] PWR_ON_RST = 8'h00;
  localparam logic [7:0] SAFE_RST   = 8'h00;
  localparam logic [7:0] WDT_VAL_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_RX   = 3'b001,
    ST_EXEC = 3'b010,
    ST_TX   = 3'b100
  } iac_state_t;

  // Hex character to {valid, value}
  function automatic logic [4:0] hexVal(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
      return {1'b1, c[3:0] + 4'h9};
    end
    return 5'h00;
  endfunction

  // Nibble to upper-case hex character
  function automatic logic [7:0] nibChar(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction
endpackage

// ---- inc/iac_reply_if.sv ----
// Reply request channel between command decoder and reply sender
`timescale 1ns/1ps
interface iac_reply_if;
  logic        start;
  logic        okFlag;
  logic [7:0]  addr;
  logic [2:0]  nibCnt;
  logic [19:0] payload;
  logic        addChk;
  logic        done;
  modport ctrl (output start, okFlag, addr, nibCnt, payload, addChk, input done);
  modport tx (input start, okFlag, addr, nibCnt, payload, addChk, output done);
endinterface

// ---- src/iac_reply_tx.sv ----
// Reply sender: delimiter, address, hex payload, optional checksum, CR
`timescale 1ns/1ps
module iac_reply_tx (
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rstSync_b,
  // Request channel
  iac_reply_if.tx     rep,
  // Character stream
  output logic        txValid,
  output logic [7:0]  txByte,
  input  wire logic   txReady
);
  logic        busy_q;
  logic        ok_q;
  logic        chk_q;
  logic        done_q;
  logic [7:0]  addr_q;
  logic [7:0]  sum_q;
  logic [3:0]  step_q;
  logic [3:0]  dataEnd;
  logic [3:0]  lastStep;
  logic [19:0] pay_q;
  logic [7:0]  charNow;
  logic        loadNow;

  assign rep.done = done_q;
  assign dataEnd  = 4'h3 + {1'b0, rep.nibCnt};
  assign lastStep = dataEnd + (chk_q ? 4'h2 : 4'h0);
  assign loadNow  = busy_q && (!txValid || txReady);

  // Character for the current step
  always_comb begin
    charNow = iac_pkg::CH_CR;
    if (step_q == 4'h0) charNow = ok_q ? iac_pkg::CH_BANG : iac_pkg::CH_QUES;
    else if (step_q == 4'h1) charNow = iac_pkg::nibChar(addr_q[7:4]);
    else if (step_q == 4'h2) charNow = iac_pkg::nibChar(addr_q[3:0]);
    else if (step_q < dataEnd) charNow = iac_pkg::nibChar(pay_q[19:16]);
    else if (chk_q && step_q == dataEnd) charNow = iac_pkg::nibChar(sum_q[7:4]);
    else if (chk_q && step_q == dataEnd + 4'h1) charNow = iac_pkg::nibChar(sum_q[3:0]);
  end

  // Sequencer; payload fields stay stable from start until done
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      busy_q  <= 1'b0;
      ok_q    <= 1'b0;
      chk_q   <= 1'b0;
      done_q  <= 1'b0;
      addr_q  <= 8'h00;
      sum_q   <= 8'h00;
      step_q  <= 4'h0;
      pay_q   <= 20'h00000;
      txValid <= 1'b0;
      txByte  <= 8'h00;
    end else begin
      done_q <= 1'b0;
      if (!busy_q && rep.start) begin
        busy_q <= 1'b1;
        ok_q   <= rep.okFlag;
        chk_q  <= rep.addChk;
        addr_q <= rep.addr;
        pay_q  <= rep.payload;
        sum_q  <= 8'h00;
        step_q <= 4'h0;
      end else if (loadNow) begin
        txValid <= 1'b1;
        txByte  <= charNow;
        step_q  <= step_q + 4'h1;
        if (step_q >= 4'h3 && step_q < dataEnd) pay_q <= {pay_q[15:0], 4'h0};
        if (step_q < dataEnd) sum_q <= sum_q + charNow;
        if (step_q == lastStep) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end else if (txValid && txReady) begin
        txValid <= 1'b0;
      end
    end
  end
endmodule

// ---- src/iac_cmd_handler.sv ----
// Command decoder and output control of the I/O alarm command handler
`timescale 1ns/1ps
module iac_cmd_handler (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // Configuration
  input  wire logic [7:0]                ownAddr,
  input  wire logic                      chkEnable,
  // Received characters
  input  wire logic                      rxValid,
  input  wire logic [7:0]                rxByte,
  // Reply characters
  output logic                           txValid,
  output logic [7:0]                     txByte,
  input  wire logic                      txReady,
  // Digital pins and alarm output assignment
  input  wire logic [iac_pkg::DIO_W-1:0] diPins,
  output logic [iac_pkg::DIO_W-1:0]      doPins,
  input  wire logic [iac_pkg::DIO_W-1:0] alarmDoMask,
  input  wire logic [iac_pkg::DIO_W-1:0] alarmDoValue,
  // Host watchdog
  input  wire logic                      wdtExpired,
  output logic                           hostAlive,
  output logic                           wdtEnable,
  output logic [7:0]                     wdtTimeout,
  // Alarm and counter control
  output logic [1:0]                     alarmMode,
  output logic                           alarmClear,
  output logic                           counterClear,
  // Stored presets
  output logic [7:0]                     powerOnValue,
  output logic [7:0]                     safeValue
);
  localparam int W = iac_pkg::DIO_W;

  iac_reply_if rep ();

  logic [1:0]          rstPipe_q;
  logic                rstSync_b;
  iac_pkg::iac_state_t state_q;
  logic [7:0]          cmdBuf_q [iac_pkg::BUF_LEN];
  logic [4:0]          hx [iac_pkg::BUF_LEN];
  logic [3:0]          len_q;
  logic                ovf_q;
  logic [W-1:0]        di1_q;
  logic [W-1:0]        di2_q;
  logic [W-1:0]        doVal_q;
  logic                wdtPrev_q;
  logic                expRise;
  logic                exec;
  // Request registers toward the reply sender
  logic                repStart_q;
  logic                repOk_q;
  logic [2:0]          repNibs_q;
  logic [19:0]         repPay_q;
  // Decoder results
  logic [7:0]          sumAll;
  logic [3:0]          chkHi;
  logic [3:0]          bodyLen;
  logic                chkOk;
  logic                commOk;
  logic                addrMatch;
  logic [7:0]          byte45;
  logic [7:0]          byte56;
  logic [7:0]          byte67;
  logic                ok45;
  logic                ok56;
  logic                ok67;
  logic                doReply;
  logic                repOk;
  logic [2:0]          nibs;
  logic [19:0]         pay;
  logic                aAlive;
  logic                aPreset;
  logic                aWdt;
  logic                aDo;
  logic                aAlmOff;
  logic                aAlmOn;
  logic                aClrA;
  logic                aClrC;
  logic                wrDoReq;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rstPipe_q <= 2'b00;
    else rstPipe_q <= {rstPipe_q[0], 1'b1};
  end
  assign rstSync_b = rstPipe_q[1];

  // Input pins cross in from outside; only the second stage is read
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      di1_q <= '0;
      di2_q <= '0;
    end else begin
      di1_q <= diPins;
      di2_q <= di1_q;
    end
  end

  // Command framing; while receiving, a delimiter restarts the buffer to resync
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      len_q <= 4'h0;
      ovf_q <= 1'b0;
      for (int i = 0; i < iac_pkg::BUF_LEN; i++) cmdBuf_q[i] <= 8'h00;
    end else if (state_q == iac_pkg::ST_RX && rxValid) begin
      if (rxByte == iac_pkg::CH_TILDE || rxByte == iac_pkg::CH_AT) begin
        cmdBuf_q[0] <= rxByte;
        len_q       <= 4'h1;
        ovf_q       <= 1'b0;
      end else if (rxByte != iac_pkg::CH_CR) begin
        if (int'(len_q) == iac_pkg::BUF_LEN) ovf_q <= 1'b1;
        else begin
          cmdBuf_q[len_q] <= rxByte;
          len_q           <= len_q + 4'h1;
        end
      end
    end else if (state_q == iac_pkg::ST_EXEC) begin
      len_q <= 4'h0;
      ovf_q <= 1'b0;
    end
  end

  // Hex value of every buffered character
  for (genvar g = 0; g < iac_pkg::BUF_LEN; g++) begin : gHex
    assign hx[g] = iac_pkg::hexVal(cmdBuf_q[g]);
  end

  // Checksum is the byte sum of all characters ahead of it
  always_comb begin
    sumAll = 8'h00;
    for (int i = 0; i < iac_pkg::BUF_LEN; i++) begin
      if (i + 2 < int'(len_q)) sumAll = sumAll + cmdBuf_q[i];
    end
  end
  assign chkHi   = (len_q >= 4'h2) ? len_q - 4'h2 : 4'h0;
  assign bodyLen = chkEnable ? chkHi : len_q;
  assign chkOk   = !chkEnable || (len_q >= 4'h4 && hx[chkHi][4] && hx[chkHi + 4'h1][4]
                   && {hx[chkHi][3:0], hx[chkHi + 4'h1][3:0]} == sumAll);
  assign commOk    = chkOk && !ovf_q && bodyLen >= iac_pkg::LEN_ALIVE;
  assign addrMatch = hx[1][4] && hx[2][4] && {hx[1][3:0], hx[2][3:0]} == ownAddr;
  assign byte45 = {hx[4][3:0], hx[5][3:0]};
  assign byte56 = {hx[5][3:0], hx[6][3:0]};
  assign byte67 = {hx[6][3:0], hx[7][3:0]};
  assign ok45   = hx[4][4] && hx[5][4];
  assign ok56   = hx[5][4] && hx[6][4];
  assign ok67   = hx[6][4] && hx[7][4];
  assign wrDoReq = cmdBuf_q[0] == iac_pkg::CH_AT && bodyLen == iac_pkg::LEN_DO
                   && cmdBuf_q[3] == iac_pkg::CH_D && cmdBuf_q[4] == iac_pkg::CH_O;

  // Command decode; anything not recognised stays silent
  always_comb begin
    doReply = 1'b0;
    repOk   = 1'b1;
    nibs    = 3'h0;
    pay     = 20'h00000;
    aAlive  = 1'b0;
    aPreset = 1'b0;
    aWdt    = 1'b0;
    aDo     = 1'b0;
    aAlmOff = 1'b0;
    aAlmOn  = 1'b0;
    aClrA   = 1'b0;
    aClrC   = 1'b0;
    if (commOk) begin
      if (cmdBuf_q[0] == iac_pkg::CH_TILDE && bodyLen == iac_pkg::LEN_ALIVE
          && cmdBuf_q[1] == iac_pkg::CH_STAR && cmdBuf_q[2] == iac_pkg::CH_STAR) begin
        aAlive = 1'b1;
      end else if (addrMatch && cmdBuf_q[0] == iac_pkg::CH_TILDE) begin
        if (cmdBuf_q[3] == iac_pkg::CH_4 && bodyLen == iac_pkg::LEN_RDPRE) begin
          doReply = 1'b1;
          nibs    = 3'h4;
          pay     = {powerOnValue, safeValue, 4'h0};
        end else if (cmdBuf_q[3] == iac_pkg::CH_5 && bodyLen == iac_pkg::LEN_SETPR
                     && ok45 && ok67) begin
          doReply = 1'b1;
          aPreset = 1'b1;
        end else if (cmdBuf_q[3] == iac_pkg::CH_3 && bodyLen == iac_pkg::LEN_WDT && ok56
                     && (cmdBuf_q[4] == iac_pkg::CH_0 || cmdBuf_q[4] == iac_pkg::CH_1)) begin
          doReply = 1'b1;
          aWdt    = 1'b1;
        end
      end else if (addrMatch && cmdBuf_q[0] == iac_pkg::CH_AT) begin
        if (bodyLen == iac_pkg::LEN_AT2 && cmdBuf_q[3] == iac_pkg::CH_C
            && cmdBuf_q[4] == iac_pkg::CH_A) begin
          doReply = 1'b1;
          aClrA   = 1'b1;
        end else if (bodyLen == iac_pkg::LEN_AT2 && cmdBuf_q[3] == iac_pkg::CH_C
                     && cmdBuf_q[4] == iac_pkg::CH_E) begin
          doReply = 1'b1;
          aClrC   = 1'b1;
        end else if (bodyLen == iac_pkg::LEN_AT2 && cmdBuf_q[3] == iac_pkg::CH_D
                     && cmdBuf_q[4] == iac_pkg::CH_A) begin
          doReply = 1'b1;
          aAlmOff = 1'b1;
        end else if (bodyLen == iac_pkg::LEN_AT2 && cmdBuf_q[3] == iac_pkg::CH_D
                     && cmdBuf_q[4] == iac_pkg::CH_I) begin
          doReply = 1'b1;
          nibs    = 3'h5;
          pay     = {2'h0, alarmMode, doPins, di2_q};
        end else if (bodyLen == iac_pkg::LEN_ENA && cmdBuf_q[3] == iac_pkg::CH_E
                     && cmdBuf_q[4] == iac_pkg::CH_A) begin
          doReply = 1'b1;
          if (cmdBuf_q[5] == iac_pkg::CH_M || cmdBuf_q[5] == iac_pkg::CH_L) aAlmOn = 1'b1;
          else repOk = 1'b0;
        end else if (wrDoReq && ok56) begin
          doReply = 1'b1;
          if (wdtExpired) repOk = 1'b0;
          else aDo = 1'b1;
        end
      end
    end
  end

  assign exec    = state_q == iac_pkg::ST_EXEC;
  assign expRise = wdtExpired && !wdtPrev_q;

  // Sequencer: collect, decide in one cycle, then wait for the reply
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) state_q <= iac_pkg::ST_RX;
    else begin
      case (state_q)
        iac_pkg::ST_RX: begin
          if (rxValid && rxByte == iac_pkg::CH_CR) state_q <= iac_pkg::ST_EXEC;
        end
        iac_pkg::ST_EXEC: state_q <= doReply ? iac_pkg::ST_TX : iac_pkg::ST_RX;
        iac_pkg::ST_TX: begin
          if (rep.done) state_q <= iac_pkg::ST_RX;
        end
        default: state_q <= iac_pkg::ST_RX;
      endcase
    end
  end

  // Reply request, held stable for the sender until done
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      repStart_q <= 1'b0;
      repOk_q    <= 1'b0;
      repNibs_q  <= 3'h0;
      repPay_q   <= 20'h00000;
    end else begin
      repStart_q <= exec && doReply;
      if (exec && doReply) begin
        repOk_q   <= repOk;
        repNibs_q <= nibs;
        repPay_q  <= pay;
      end
    end
  end
  assign rep.start   = repStart_q;
  assign rep.okFlag  = repOk_q;
  assign rep.addr    = ownAddr;
  assign rep.nibCnt  = repNibs_q;
  assign rep.payload = repPay_q;
  assign rep.addChk  = chkEnable;

  iac_reply_tx uTx (
    .sys_clk   (sys_clk),
    .rstSync_b (rstSync_b),
    .rep       (rep),
    .txValid   (txValid),
    .txByte    (txByte),
    .txReady   (txReady)
  );

  // Stored presets
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      powerOnValue <= iac_pkg::PWR_ON_RST;
      safeValue    <= iac_pkg::SAFE_RST;
    end else if (exec && aPreset) begin
      powerOnValue <= byte45;
      safeValue    <= byte67;
    end
  end

  // Watchdog settings; expiry wins over a config's enable bit in the same cycle, but its timeout still loads
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      wdtPrev_q  <= 1'b0;
      wdtEnable  <= 1'b0;
      wdtTimeout <= iac_pkg::WDT_VAL_RST;
    end else begin
      wdtPrev_q <= wdtExpired;
      if (expRise) wdtEnable <= 1'b0;
      else if (exec && aWdt) wdtEnable <= cmdBuf_q[4] == iac_pkg::CH_1;
      if (exec && aWdt) wdtTimeout <= byte56;
    end
  end

  // Host-alive pulse restarts the external watchdog countdown
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) hostAlive <= 1'b0;
    else hostAlive <= exec && aAlive;
  end

  // Output value; alarm-assigned bits keep their old value in every load
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) doVal_q <= iac_pkg::PWR_ON_RST;
    else if (expRise) begin
      doVal_q <= (safeValue & ~alarmDoMask) | (doVal_q & alarmDoMask);
    end else if (exec && aDo) begin
      doVal_q <= (byte56 & ~alarmDoMask) | (doVal_q & alarmDoMask);
    end
  end

  // Each output pin follows the alarm logic when assigned to it
  for (genvar g = 0; g < W; g++) begin : gDo
    always_ff @(posedge sys_clk or negedge rstSync_b) begin
      if (!rstSync_b) doPins[g] <= 1'b0;
      else doPins[g] <= alarmDoMask[g] ? alarmDoValue[g] : doVal_q[g];
    end
  end

  // Alarm setting and one-cycle clear strobes to the alarm and counter logic
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      alarmMode    <= iac_pkg::ALM_OFF;
      alarmClear   <= 1'b0;
      counterClear <= 1'b0;
    end else begin
      alarmClear   <= exec && aClrA;
      counterClear <= exec && aClrC;
      if (exec && aAlmOff) alarmMode <= iac_pkg::ALM_OFF;
      else if (exec && aAlmOn) begin
        alarmMode <= (cmdBuf_q[5] == iac_pkg::CH_M) ? iac_pkg::ALM_MOM
                                                    : iac_pkg::ALM_LAT;
      end
    end
  end

  // Checks on the decoder and the output control
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync_b);

  wdt_clear_a: assert property ($rose(wdtExpired) |=> !wdtEnable)
    else $error("watchdog enable not cleared on expiry");
  safe_load_a: assert property ($rose(wdtExpired) |=>
      ((doVal_q ^ $past(safeValue)) & ~$past(alarmDoMask)) == '0)
    else $error("safe value not loaded on expiry");
  alarm_pin_a: assert property (1'b1 |=>
      ((doPins ^ $past(alarmDoValue)) & $past(alarmDoMask)) == '0)
    else $error("alarm-assigned output not under alarm control");
  wdt_reject_a: assert property (exec && commOk && addrMatch && wrDoReq && ok56
      && wdtExpired && wdtPrev_q |=> repStart_q && !repOk_q && $stable(doVal_q))
    else $error("write-output not rejected during expiry");
  silent_addr_a: assert property (exec && !addrMatch |=> !repStart_q)
    else $error("reply to foreign address");
  preset_store_a: assert property (exec && aPreset |=>
      powerOnValue == $past(byte45) && safeValue == $past(byte67))
    else $error("presets not stored");
  alarm_mode_a: assert property (exec && aAlmOn && cmdBuf_q[5] == iac_pkg::CH_L
      |=> (alarmMode == iac_pkg::ALM_LAT) [*2])
    else $error("latched alarm mode not set");
  clr_count_a: assert property (exec && aClrC |=> counterClear ##1 !counterClear)
    else $error("counter clear strobe wrong");
  reply_head_a: assert property (exec && doReply |-> ##[2:8] txValid
      && (txByte == iac_pkg::CH_BANG || txByte == iac_pkg::CH_QUES))
    else $error("reply delimiter missing");
  alive_quiet_a: assert property (exec && aAlive |=> hostAlive && !repStart_q)
    else $error("host-alive handled wrongly");

  alive_c: cover property (exec && aAlive);
  status_c: cover property (exec && doReply && nibs == 3'h5);
  write_c: cover property (exec && aDo ##[1:4] doPins != $past(doPins));
  reject_c: cover property (exec && doReply && !repOk);
endmodule

// ---- bench/iac_host_model.sv ----
// Host side model: takes reply characters, optionally stalling
`timescale 1ns/1ps
module iac_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Reply stream
  input  wire logic       txValid,
  input  wire logic [7:0] txByte,
  output logic            txReady,
  // Pace control
  input  wire logic       slow
);
  string rx = "";
  logic  ph = 1'b0;
  // Slow pace accepts every other cycle so the sender must hold its char
  always @(posedge sys_clk) begin
    ph <= ~ph;
    if (txValid && txReady) rx = {rx, string'(txByte)};
  end
  assign txReady = !slow || ph;
endmodule

// ---- bench/tb_iac_cmd_handler.sv ----
// Self-checking bench of the I/O alarm command handler
`timescale 1ns/1ps
module tb_iac_cmd_handler;
  logic       sys_clk = 1'b0, rst_b = 1'b0, rxValid = 1'b0, wdtExpired = 1'b0, slow = 1'b0;
  logic [7:0] rxByte = 8'h00, diPins = 8'h00, mask = 8'h00, almVal = 8'h00;
  logic       txValid, txReady, hostAlive, wdtEnable, alarmClear, counterClear, chk = 1'b0;
  logic [7:0] txByte, doPins, wdtTimeout, powerOnValue, safeValue;
  logic [1:0] alarmMode;
  int         n_errors = 0, n_tests = 0, nHa = 0, nAc = 0, nCc = 0;

  iac_cmd_handler u_iac_cmd_handler (.sys_clk, .rst_b, .ownAddr(8'h01), .chkEnable(chk),
    .rxValid, .rxByte, .txValid, .txByte, .txReady, .diPins, .doPins,
    .alarmDoMask(mask), .alarmDoValue(almVal), .wdtExpired, .hostAlive, .wdtEnable,
    .wdtTimeout, .alarmMode, .alarmClear, .counterClear, .powerOnValue, .safeValue);
  iac_host_model u_iac_host_model (.sys_clk, .txValid, .txByte, .txReady, .slow);

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Count pulses, so a missed or doubled pulse shows in the totals
  always @(posedge sys_clk) begin
    nHa += hostAlive;
    nAc += alarmClear;
    nCc += counterClear;
  end

  task automatic chkB(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkS(string nm, string e, string g);
    n_tests++;
    if (g != e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %s seen %s", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Send a command, then compare the whole reply; empty means silence
  task automatic cmd(string s, string e);
    int i;
    u_iac_host_model.rx = "";
    for (i = 0; i < s.len(); i++) begin
      rxValid <= 1'b1;
      rxByte  <= s[i];
      @(posedge sys_clk);
    end
    rxByte <= 8'h0d;
    @(posedge sys_clk);
    rxValid <= 1'b0;
    for (i = 0; i < 90; i++) begin
      @(posedge sys_clk);
      if (u_iac_host_model.rx.len() > e.len()) break;
    end
    if (e != "" && i == 90) begin
      n_errors++;
      final_report();
    end else begin
      chkS({"reply ", s}, (e == "") ? "" : {e, "\r"}, u_iac_host_model.rx);
    end
    @(posedge sys_clk); // Let the handler return to idle first
  endtask

  task automatic tPreset();
    slow <= 1'b1;
    cmd("~0150102", "!01");
    chkB("powerOnValue", 8'h01, powerOnValue);
    chkB("safeValue", 8'h02, safeValue);
    cmd("~015zz77", "");
    cmd("~0257788", "");
    cmd("~014", "!010102");
    // Checksummed frames: a good sum gets a summed reply, a bad one silence
    chk <= 1'b1;
    cmd("~01413", "!01010245");
    cmd("~01400", "");
    chk <= 1'b0;
    cmd("~**", "");
    chkB("hostAlive", 8'h01, nHa[7:0]);
    slow <= 1'b0;
    $display("test preset done");
  endtask
  task automatic tDigital();
    diPins <= 8'h96;
    cmd("@01DO5a", "!01");
    chkB("doPins", 8'h5a, doPins);
    cmd("@01DI", "!0105A96");
    $display("test digital done");
  endtask
  task automatic tAlarm();
    cmd("@01EAM", "!01");
    chkB("alarmMode", iac_pkg::ALM_MOM, alarmMode);
    cmd("@01DI", "!0115A96");
    cmd("@01EAL", "!01");
    cmd("@01EAX", "?01");
    cmd("@01DI", "!0125A96");
    cmd("@01CA", "!01");
    chkB("alarmClear", 8'h01, nAc[7:0]);
    cmd("@01DA", "!01");
    chkB("alarmMode", iac_pkg::ALM_OFF, alarmMode);
    cmd("@01CE", "!01");
    chkB("counterClear", 8'h01, nCc[7:0]);
    $display("test alarm done");
  endtask
  task automatic tWatchdog();
    mask   <= 8'h0f;
    almVal <= 8'h03;
    cmd("~015c3a5", "!01");
    cmd("~013164", "!01");
    chkB("wdtEnable", 8'h01, wdtEnable);
    chkB("wdtTimeout", 8'h64, wdtTimeout);
    cmd("@01DOff", "!01");
    chkB("doPins", 8'hf3, doPins);
    wdtExpired <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chkB("wdtEnable", 8'h00, wdtEnable);
    chkB("doPins", 8'ha3, doPins);
    cmd("@01DO00", "?01");
    chkB("doPins", 8'ha3, doPins);
    wdtExpired <= 1'b0;
    // Supervision only comes back when the host asks again
    cmd("~013164", "!01");
    chkB("wdtEnable", 8'h01, wdtEnable);
    cmd("~01300a", "!01");
    chkB("wdtEnable", 8'h00, wdtEnable);
    chkB("wdtTimeout", 8'h0a, wdtTimeout);
    $display("test watchdog done");
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chkB("doPins", iac_pkg::PWR_ON_RST, doPins);
    tPreset();
    tDigital();
    tAlarm();
    tWatchdog();
    final_report();
  end
endmodule
